// ===== design/rst_pkg.sv
// package: register layout, reset cause codes and timing counts of the reset source tracker
package rst_pkg;
   // ==========================================================
   // register map
   localparam logic [3:0] RST_ADDR_STATUS = 4'h0;
   localparam logic [3:0] RST_ADDR_CAUSE = 4'h4;
   // ==========================================================
   // field positions of reset_status_control
   localparam int RST_BIT_IRQ_PRIORITY_ENABLE = 7;
   localparam int RST_BIT_SW_BROWNOUT_ENABLE = 6;
   localparam int RST_BIT_UNUSED = 5;
   localparam int RST_BIT_RI = 4;
   localparam int RST_BIT_WDT = 3;
   localparam int RST_BIT_SLEEP = 2;
   localparam int RST_BIT_POR = 1;
   localparam int RST_BIT_BOR = 0;
   // ==========================================================
   // brown-out configuration codes
   localparam logic [1:0] RST_BOR_OFF = 2'h0;
   localparam logic [1:0] RST_BOR_SW = 2'h1;
   localparam logic [1:0] RST_BOR_NOSLEEP = 2'h2;
   localparam logic [1:0] RST_BOR_ON = 2'h3;
   // ==========================================================
   // timing: least low time of the reset pin that counts as a reset
   localparam int RST_PIN_FILTER_NS = 200;
   localparam int RST_CLK_PERIOD_NS = 50;
   localparam int RST_PIN_FILTER_CYC = (RST_PIN_FILTER_NS + RST_CLK_PERIOD_NS - 1)
      / RST_CLK_PERIOD_NS;
   localparam int RST_FILT_W = 4;
   // ==========================================================
   // reset cause codes
   typedef enum logic [7:0] {
      RST_C_POR = 8'h01,
      RST_C_PIN_RUN = 8'h02,
      RST_C_PIN_PM = 8'h04,
      RST_C_WDT = 8'h08,
      RST_C_BOR = 8'h10,
      RST_C_INSTR = 8'h20,
      RST_C_STK_FULL = 8'h40,
      RST_C_STK_UNDER = 8'h80
   } rst_cause_e;
   // on-chip events arriving on the core clock
   typedef struct packed {
      logic wdt_expire;
      logic reset_instr;
      logic stack_full;
      logic stack_under;
      logic watchdog_kick_instr;
      logic sleep_instr;
      logic power_managed;
   } rst_evt_s;
   // pin filter states
   typedef enum logic [2:0] {
      RST_F_HIGH = 3'b001,
      RST_F_COUNT = 3'b010,
      RST_F_LOW = 3'b100
   } rst_filt_e;
   typedef struct packed {
      logic irq_priority_enable;
      logic sw_brownout_enable;
      logic reset_instr_flag;
      logic watchdog_expiry_flag;
      logic sleep_entered_flag;
      logic por_flag;
      logic brownout_flag;
      logic [7:0] last_cause;
      rst_filt_e filt;
      logic [RST_FILT_W-1:0] filt_cnt;
      logic pin_s1;
      logic pin_s2;
      logic good_s1;
      logic good_s2;
      logic good_d;
      logic bo_s1;
      logic bo_s2;
      logic por_pend;
      logic [1:0] rel;
      logic strap_done;
      logic [7:0] rdata;
   } rst_state_s;
endpackage

// ===== design/rst_source_track.sv
// reset source tracker: pin filter, power-on and brown-out detect, status register
// ==========================================================
// What this block does
// R1: tell apart eight distinct reset causes
// R2: low five bits are event flags
// R3: bit 7 enables interrupt priority levels
// R4: bit 6 gates brown-out only in mode 01
// R5: bit 6 resets to 1 only in mode 01
// R6: bit 5 ignores writes, reads zero
// R7: bit 4 clears on reset instruction
// R8: bit 3 sets on power/kick/sleep, clears on expiry
// R9: bit 2 sets on power/kick, clears on sleep
// R10: bit 1 clears on power-on only, software sets
// R11: bit 0 clears on brown-out, software sets
// R12: power-on and brown-out reset values fixed
// R13: software reads brown-out as 0 with 1
// R14: software re-arms power-on flag after detection
// R15: held low pin keeps device in reset
// R16: short low pin pulses are filtered out
// R17: weak pull-up on while pin is reset input
// R18: reset pin is never driven low
// R19: pin disabled acts as plain input
// R20: supply-good rise issues power-on reset
// R21: brown-out flag cleared on brown-out or power-on
// R22: decode four brown-out configuration modes
// R23: sources ORed, async assert, sync release
// R24: reset event beats software write
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module rst_source_track
   import rst_pkg::*;
#(
   parameter int FILTER_CYC = RST_PIN_FILTER_CYC
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic ext_reset_pin_in,
   output logic ext_reset_pin_out,
   output logic ext_reset_pin_oe,
   output logic ext_reset_pin_pullup,
   output logic pin_digital_in,
   input wire logic ext_reset_pin_enable,
   input wire logic [1:0] brownout_config_mode,
   input wire logic supply_good,
   input wire logic brownout_detect,
   input wire rst_evt_s evt,
   output logic brownout_active,
   output logic core_reset_n
);
   rst_state_s q;
   rst_state_s next_q;
   logic pin_reset;
   logic por_evt;
   logic bor_evt;
   logic any_reset;
   logic wr_stat;
   logic [7:0] stat;
   logic [7:0] cause_now;
   logic arst_n;

   // ==========================================================
   // brown-out enable decode
   always_comb begin
      case (brownout_config_mode) // R22
         RST_BOR_OFF: brownout_active = 1'b0;
         RST_BOR_SW: brownout_active = q.sw_brownout_enable; // R4
         RST_BOR_NOSLEEP: brownout_active = ~evt.power_managed;
         RST_BOR_ON: brownout_active = 1'b1;
         default: brownout_active = 1'b0;
      endcase
   end

   // ==========================================================
   // source combination
   assign pin_reset = ext_reset_pin_enable & (q.filt == RST_F_LOW); // R15 R19
   assign por_evt = q.good_s2 & ~q.good_d; // R20
   assign bor_evt = q.bo_s2 & brownout_active;
   assign any_reset = por_evt | bor_evt | pin_reset | evt.wdt_expire | evt.reset_instr
      | evt.stack_full | evt.stack_under;
   assign wr_stat = wr & (addr == RST_ADDR_STATUS);

   always_comb begin
      cause_now = 8'h00; // R1
      if (por_evt) cause_now = RST_C_POR;
      else if (bor_evt) cause_now = RST_C_BOR;
      else if (pin_reset & evt.power_managed) cause_now = RST_C_PIN_PM;
      else if (pin_reset) cause_now = RST_C_PIN_RUN;
      else if (evt.wdt_expire) cause_now = RST_C_WDT;
      else if (evt.reset_instr) cause_now = RST_C_INSTR;
      else if (evt.stack_full) cause_now = RST_C_STK_FULL;
      else if (evt.stack_under) cause_now = RST_C_STK_UNDER;
   end

   // ==========================================================
   // pin: input only, pull-up while it serves as reset input
   assign ext_reset_pin_out = 1'b1; // R18
   assign ext_reset_pin_oe = 1'b1; // R18
   assign ext_reset_pin_pullup = ext_reset_pin_enable; // R17
   assign pin_digital_in = q.pin_s2;

   // status image; sbor bit reads zero outside software mode
   always_comb begin
      stat = 8'h00;
      stat[RST_BIT_IRQ_PRIORITY_ENABLE] = q.irq_priority_enable;
      stat[RST_BIT_SW_BROWNOUT_ENABLE] = (brownout_config_mode == RST_BOR_SW) & q.sw_brownout_enable;
      stat[RST_BIT_UNUSED] = 1'b0; // R6
      stat[RST_BIT_RI] = q.reset_instr_flag;
      stat[RST_BIT_WDT] = q.watchdog_expiry_flag;
      stat[RST_BIT_SLEEP] = q.sleep_entered_flag;
      stat[RST_BIT_POR] = q.por_flag;
      stat[RST_BIT_BOR] = q.brownout_flag;
   end

   // ==========================================================
   // next state
   always_comb begin
      next_q = q;
      next_q.pin_s1 = ext_reset_pin_in;
      next_q.pin_s2 = q.pin_s1;
      next_q.good_s1 = supply_good;
      next_q.good_s2 = q.good_s1;
      next_q.good_d = q.good_s2;
      next_q.bo_s1 = brownout_detect;
      next_q.bo_s2 = q.bo_s1;
      next_q.strap_done = 1'b1;
      // strap is caught after release of nrst, not under it
      if (!q.strap_done) begin
         next_q.sw_brownout_enable = (brownout_config_mode == RST_BOR_SW); // R5
      end
      // filter: a low must persist FILTER_CYC+1 sampled cycles to count
      case (q.filt) // R16
         RST_F_HIGH: begin
            if (!q.pin_s2) begin
               next_q.filt = RST_F_COUNT;
               next_q.filt_cnt = '0;
            end
         end
         RST_F_COUNT: begin
            if (q.pin_s2) next_q.filt = RST_F_HIGH;
            else if (32'(q.filt_cnt) >= FILTER_CYC - 1) next_q.filt = RST_F_LOW;
            else next_q.filt_cnt = q.filt_cnt + 1'b1;
         end
         RST_F_LOW: begin
            if (q.pin_s2) next_q.filt = RST_F_HIGH;
         end
         default: next_q.filt = RST_F_HIGH;
      endcase
      // software writes first, so hardware events below win
      if (wr_stat) begin // R2
         next_q.irq_priority_enable = wdata[RST_BIT_IRQ_PRIORITY_ENABLE]; // R3
         if (brownout_config_mode == RST_BOR_SW) begin
            next_q.sw_brownout_enable = wdata[RST_BIT_SW_BROWNOUT_ENABLE]; // R4
         end
         next_q.reset_instr_flag = wdata[RST_BIT_RI];
         next_q.por_flag = wdata[RST_BIT_POR]; // R10
         next_q.brownout_flag = wdata[RST_BIT_BOR]; // R11
      end
      if (evt.watchdog_kick_instr) begin
         next_q.watchdog_expiry_flag = 1'b1; // R8
         next_q.sleep_entered_flag = 1'b1; // R9
      end
      if (evt.sleep_instr) begin
         next_q.watchdog_expiry_flag = 1'b1; // R8
         next_q.sleep_entered_flag = 1'b0; // R9
      end
      if (evt.wdt_expire) next_q.watchdog_expiry_flag = 1'b0; // R8 R24
      if (evt.reset_instr) next_q.reset_instr_flag = 1'b0; // R7 R24
      if (bor_evt) begin // R12 R21 R24
         next_q.brownout_flag = 1'b0;
         next_q.irq_priority_enable = 1'b0;
         next_q.reset_instr_flag = 1'b1;
         next_q.watchdog_expiry_flag = 1'b1;
         next_q.sleep_entered_flag = 1'b1;
         next_q.sw_brownout_enable = (brownout_config_mode == RST_BOR_SW);
      end
      if (por_evt) begin // R12 R20 R24
         next_q.por_flag = 1'b0; // R10
         next_q.brownout_flag = 1'b0; // R21
         next_q.irq_priority_enable = 1'b0;
         next_q.reset_instr_flag = 1'b1; // R7
         next_q.watchdog_expiry_flag = 1'b1;
         next_q.sleep_entered_flag = 1'b1;
         next_q.sw_brownout_enable = (brownout_config_mode == RST_BOR_SW); // R5
      end
      if (any_reset) next_q.last_cause = cause_now; // R1
      // release stretcher: any source reloads it
      if (any_reset) next_q.rel = 2'b00; // R23
      else next_q.rel = {q.rel[0], 1'b1};
      next_q.rdata = 8'h00;
      if (rd) begin
         case (addr)
            RST_ADDR_STATUS: next_q.rdata = stat;
            RST_ADDR_CAUSE: next_q.rdata = q.last_cause;
            default: next_q.rdata = 8'h00;
         endcase
      end
   end

   // ==========================================================
   // registers; bus reset gives the power-on image
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         q <= '0;
         q.reset_instr_flag <= 1'b1; // R12
         q.watchdog_expiry_flag <= 1'b1;
         q.sleep_entered_flag <= 1'b1;
         q.filt <= RST_F_HIGH;
         q.pin_s1 <= 1'b1;
         q.pin_s2 <= 1'b1;
         // supply sync idles high so that leaving nrst is not taken for a power-up
         q.good_s1 <= 1'b1;
         q.good_s2 <= 1'b1;
         q.good_d <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   assign rdata = q.rdata;
   // asserted at once by any source, released on the clock after two quiet edges
   assign arst_n = ~any_reset & nrst; // R23
   assign core_reset_n = arst_n & q.rel[1];

   // ==========================================================
   // checks
   property p_por_clear;
      @(posedge ref_clk) disable iff (!nrst) por_evt |=> (stat[RST_BIT_POR] == 1'b0)
         && (stat[RST_BIT_BOR] == 1'b0) && stat[RST_BIT_RI] && !stat[RST_BIT_IRQ_PRIORITY_ENABLE];
   endproperty
   a_por_clear: assert property (p_por_clear) else $error("power-on image wrong"); // R12
   property p_bor_clear;
      @(posedge ref_clk) disable iff (!nrst) bor_evt |=> !q.brownout_flag;
   endproperty
   a_bor_clear: assert property (p_bor_clear) else $error("brown-out flag not cleared"); // R11
   property p_por_no_hw_set;
      @(posedge ref_clk) disable iff (!nrst) (!q.por_flag && !wr_stat) |=> !q.por_flag;
   endproperty
   a_por_no_hw_set: assert property (p_por_no_hw_set) else $error("por flag set by hw"); // R10
   property p_ri;
      @(posedge ref_clk) disable iff (!nrst) (evt.reset_instr && !por_evt && !bor_evt)
         |=> !q.reset_instr_flag;
   endproperty
   a_ri: assert property (p_ri) else $error("reset instr flag not cleared"); // R7
   property p_wdt;
      @(posedge ref_clk) disable iff (!nrst) (evt.wdt_expire && !por_evt && !bor_evt)
         |=> !q.watchdog_expiry_flag;
   endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog flag not cleared"); // R8
   property p_sleep;
      @(posedge ref_clk) disable iff (!nrst) (evt.sleep_instr && !evt.watchdog_kick_instr
         && !por_evt && !bor_evt) |=> !q.sleep_entered_flag;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep flag not cleared"); // R9
   property p_unused;
      @(posedge ref_clk) disable iff (!nrst)
         (rd && addr == RST_ADDR_STATUS) |=> (rdata[RST_BIT_UNUSED] == 1'b0);
   endproperty
   a_unused: assert property (p_unused) else $error("bit 5 read nonzero"); // R6
   property p_sbor_ro;
      @(posedge ref_clk) disable iff (!nrst) (rd && addr == RST_ADDR_STATUS
         && brownout_config_mode != RST_BOR_SW) |=> !rdata[RST_BIT_SW_BROWNOUT_ENABLE];
   endproperty
   a_sbor_ro: assert property (p_sbor_ro) else $error("bit 6 not inert"); // R4
   property p_pin_hold;
      @(posedge ref_clk) disable iff (!nrst) pin_reset |-> !core_reset_n;
   endproperty
   a_pin_hold: assert property (p_pin_hold) else $error("pin reset not held"); // R15
   property p_glitch;
      @(posedge ref_clk) disable iff (!nrst)
         q.pin_s2 |=> (q.filt == RST_F_HIGH);
   endproperty
   a_glitch: assert property (p_glitch) else $error("high pin did not end filter"); // R16
   property p_release;
      @(posedge ref_clk) disable iff (!nrst) any_reset |=> !core_reset_n;
   endproperty
   a_release: assert property (p_release) else $error("release not delayed"); // R23
   property p_pullup;
      @(posedge ref_clk) disable iff (!nrst) ext_reset_pin_pullup == ext_reset_pin_enable
         && ext_reset_pin_oe;
   endproperty
   a_pullup: assert property (p_pullup) else $error("pin drive or pull-up wrong"); // R17 R18

   // ==========================================================
   // checks: flags that only software, power-on or brown-out may raise, and the watchdog and sleep flags that kick and sleep set
   property p_bor_no_hw_set;
      @(posedge ref_clk) disable iff (!nrst)
         (!q.brownout_flag && !wr_stat) |=> !q.brownout_flag;
   endproperty
   a_bor_no_hw_set: assert property (p_bor_no_hw_set) else $error("bor flag set by hw"); // R11
   property p_por_keep;
      @(posedge ref_clk) disable iff (!nrst)
         (!por_evt && !wr_stat) |=> $stable(q.por_flag);
   endproperty
   a_por_keep: assert property (p_por_keep) else $error("por flag moved"); // R10
   property p_ri_no_hw_set;
      @(posedge ref_clk) disable iff (!nrst)
         (!q.reset_instr_flag && !wr_stat && !por_evt && !bor_evt) |=> !q.reset_instr_flag;
   endproperty
   a_ri_no_hw_set: assert property (p_ri_no_hw_set) else $error("ri flag set by hw"); // R7
   property p_wdt_set;
      @(posedge ref_clk) disable iff (!nrst)
         ((evt.watchdog_kick_instr || evt.sleep_instr) && !evt.wdt_expire)
         |=> q.watchdog_expiry_flag;
   endproperty
   a_wdt_set: assert property (p_wdt_set) else $error("watchdog flag not set"); // R8
   property p_sleep_set;
      @(posedge ref_clk) disable iff (!nrst)
         (evt.watchdog_kick_instr && !evt.sleep_instr) |=> q.sleep_entered_flag;
   endproperty
   a_sleep_set: assert property (p_sleep_set) else $error("sleep flag not set"); // R9
   // ==========================================================
   // checks: control bits, strap and brown-out image
   property p_irq_priority_enable_write;
      @(posedge ref_clk) disable iff (!nrst)
         (wr_stat && !por_evt && !bor_evt)
         |=> (q.irq_priority_enable == $past(wdata[RST_BIT_IRQ_PRIORITY_ENABLE]));
   endproperty
   a_irq_priority_enable_write: assert property (p_irq_priority_enable_write) else $error("priority bit not written"); // R3
   property p_irq_priority_enable_hold;
      @(posedge ref_clk) disable iff (!nrst)
         (!wr_stat && !por_evt && !bor_evt) |=> $stable(q.irq_priority_enable);
   endproperty
   a_irq_priority_enable_hold: assert property (p_irq_priority_enable_hold) else $error("priority bit moved"); // R3
   property p_bor_image;
      @(posedge ref_clk) disable iff (!nrst) bor_evt |=> !q.irq_priority_enable
         && q.reset_instr_flag && q.watchdog_expiry_flag && q.sleep_entered_flag;
   endproperty
   a_bor_image: assert property (p_bor_image) else $error("brown-out image wrong"); // R12
   property p_strap;
      @(posedge ref_clk) disable iff (!nrst)
         por_evt |=> (q.sw_brownout_enable == ($past(brownout_config_mode) == RST_BOR_SW));
   endproperty
   a_strap: assert property (p_strap) else $error("sbor strap wrong"); // R5
   // a write outside mode 01 must not reach the hidden enable either
   property p_sbor_lock;
      @(posedge ref_clk) disable iff (!nrst) (wr_stat && q.strap_done && !por_evt && !bor_evt
         && brownout_config_mode != RST_BOR_SW) |=> $stable(q.sw_brownout_enable);
   endproperty
   a_sbor_lock: assert property (p_sbor_lock) else $error("bit 6 written outside mode 01"); // R4
   property p_mode_off;
      @(posedge ref_clk) disable iff (!nrst)
         (brownout_config_mode == RST_BOR_OFF) |-> !brownout_active;
   endproperty
   a_mode_off: assert property (p_mode_off) else $error("brown-out on in mode 00"); // R22
   property p_mode_on;
      @(posedge ref_clk) disable iff (!nrst)
         (brownout_config_mode == RST_BOR_ON) |-> brownout_active;
   endproperty
   a_mode_on: assert property (p_mode_on) else $error("brown-out off in mode 11"); // R22
   property p_mode_sleep;
      @(posedge ref_clk) disable iff (!nrst)
         (brownout_config_mode == RST_BOR_NOSLEEP)
         |-> (brownout_active == !evt.power_managed);
   endproperty
   a_mode_sleep: assert property (p_mode_sleep) else $error("brown-out wrong in mode 10"); // R22
   // ==========================================================
   // checks: cause record, pin path and release
   property p_cause_onehot;
      @(posedge ref_clk) disable iff (!nrst) any_reset |=> $onehot(q.last_cause);
   endproperty
   a_cause_onehot: assert property (p_cause_onehot) else $error("cause not one-hot"); // R1
   property p_filt_short;
      @(posedge ref_clk) disable iff (!nrst)
         (q.filt == RST_F_COUNT && 32'(q.filt_cnt) < FILTER_CYC - 1)
         |=> (q.filt != RST_F_LOW);
   endproperty
   a_filt_short: assert property (p_filt_short) else $error("filter ended early"); // R16
   // the plain input view lags the pin by the two synchroniser flops
   property p_pin_sync;
      @(posedge ref_clk) disable iff (!nrst) pin_digital_in == $past(ext_reset_pin_in, 2);
   endproperty
   a_pin_sync: assert property (p_pin_sync) else $error("digital input view wrong"); // R19
   property p_quiet_release;
      @(posedge ref_clk) disable iff (!nrst)
         (!any_reset ##1 !any_reset ##1 !any_reset) |-> core_reset_n;
   endproperty
   a_quiet_release: assert property (p_quiet_release) else $error("reset not released"); // R23
endmodule
`default_nettype wire

// ===== sim/rst_partner.sv
// far-side model: external reset pin wiring with its pull-up
`timescale 1ns/100ps
`default_nettype none
module rst_partner (
   input wire logic ref_clk,
   input wire logic hold_low,
   input wire logic pin_out,
   input wire logic pin_oe,
   input wire logic pin_pullup,
   output logic pin_level
);
   logic wander = 1'b1;
   // an undriven pin without pull-up wanders, so a missing pull-up cannot pass by luck
   always @(posedge ref_clk) wander <= ~wander;
   always_comb begin
      if (!pin_oe) pin_level = pin_out;
      else if (hold_low) pin_level = 1'b0;
      else if (pin_pullup) pin_level = 1'b1;
      else pin_level = wander;
   end
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// testbench: register, event, pin and supply checks of the reset source tracker
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import rst_pkg::*;
   localparam int FC = 4;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata, v;
   logic pin_in, pin_out, pin_oe, pin_pu, pin_dig, bo_act, core_n, saw_rst;
   int n_rst = 0;
   int rst0 = 0;
   logic hold_low = 1'b0;
   logic pin_en = 1'b1;
   logic [1:0] mode = 2'h1;
   logic supply_good = 1'b1;
   logic bo_det = 1'b0;
   logic [5:0] ev = 6'h00;
   logic pm = 1'b0;
   rst_evt_s evt;
   int n_fail = 0;
   int compares = 0;
   int cyc = 0;
   int seed = 32'he5f5e807;
   int st, d;
   logic [7:0] q[$];
   assign evt = {ev, pm};
   // one writer per counter: the clock process counts resets, tasks keep a mark
   assign saw_rst = (n_rst != rst0);
   rst_source_track #(.FILTER_CYC(FC)) rst_source_track_i (.ref_clk(ref_clk), .nrst(nrst),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ext_reset_pin_in(pin_in),
      .ext_reset_pin_out(pin_out), .ext_reset_pin_oe(pin_oe), .ext_reset_pin_pullup(pin_pu),
      .pin_digital_in(pin_dig), .ext_reset_pin_enable(pin_en), .brownout_config_mode(mode),
      .supply_good(supply_good), .brownout_detect(bo_det), .evt(evt),
      .brownout_active(bo_act), .core_reset_n(core_n));
   rst_partner rst_partner_i (.ref_clk(ref_clk), .hold_low(hold_low), .pin_out(pin_out),
      .pin_oe(pin_oe), .pin_pullup(pin_pu), .pin_level(pin_in));
   initial forever #25 ref_clk = ~ref_clk;
   // ==========================================================
   // helpers
   task automatic end_sim();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // timeout well above the few hundred cycles the sequence needs
   always @(posedge ref_clk) begin
      cyc++;
      if (!core_n) n_rst++;
      if (cyc == 8000) begin
         n_fail++;
         end_sim();
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] dd);
      @(posedge ref_clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= dd;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] dd);
      @(posedge ref_clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1 dd = rdata;
   endtask
   task automatic wst(input logic [7:0] dd);
      wr_reg(RST_ADDR_STATUS, dd);
      st = (dd & 8'hd3) | (st & 8'h0c);
      if (mode != 2'h1) st[6] = 1'b0;
   endtask
   task automatic chk_st();
      logic [7:0] r;
      rd_reg(RST_ADDR_STATUS, r);
      check(r, st[7:0]);
   endtask
   task automatic cause();
      logic [7:0] r;
      logic dup;
      rd_reg(RST_ADDR_CAUSE, r);
      dup = 1'b0;
      foreach (q[i]) if (q[i] === r) dup = 1'b1;
      check({7'h0, $onehot(r)}, 8'h01);
      check({7'h0, dup}, 8'h00);
      q.push_back(r);
   endtask
   task automatic rst_seen();
      check({7'h0, saw_rst}, 8'h01);
      check({7'h0, core_n}, 8'h01);
      cause();
   endtask
   task automatic pulse(input int k, input logic w);
      rst0 = n_rst;
      @(posedge ref_clk);
      ev <= 6'h01 << k;
      wr <= w;
      addr <= RST_ADDR_STATUS;
      wdata <= st[7:0] | 8'h10;
      @(posedge ref_clk);
      ev <= 6'h00;
      wr <= 1'b0;
      tick(4);
   endtask
   task automatic pin_low(input int n);
      rst0 = n_rst;
      @(posedge ref_clk);
      hold_low <= 1'b1;
      tick(n);
      #1 if (n > 8 && pin_en) check({7'h0, core_n}, 8'h00);
      if (n > 8 && !pin_en) check({7'h0, pin_dig}, 8'h00);
      @(posedge ref_clk);
      hold_low <= 1'b0;
      tick(10);
   endtask
   task automatic src(input logic b);
      rst0 = n_rst;
      @(posedge ref_clk);
      if (b) bo_det <= 1'b1;
      else supply_good <= 1'b0;
      tick(8);
      bo_det <= 1'b0;
      supply_good <= 1'b1;
      tick(10);
   endtask
   // ==========================================================
   // main sequence
   initial begin
      tick(16);
      nrst <= 1'b1;
      tick(2);
      st = 8'h5c;
      chk_st();
      rd_reg(4'h2, v);
      check(v, 8'h00);
      wst(8'hff);
      chk_st();
      wst(8'h00);
      chk_st();
      repeat (8) begin
         d = $random(seed);
         wst(d[7:0]);
         chk_st();
      end
      for (int m = 0; m < 4; m++) begin
         for (int p = 0; p < 2; p++) begin
            @(posedge ref_clk);
            mode <= m[1:0];
            pm <= p[0];
            wr_reg(RST_ADDR_STATUS, 8'h40);
            rd_reg(RST_ADDR_STATUS, v);
            check({7'h0, v[6]}, {7'h0, m == 1});
            check({7'h0, bo_act}, {7'h0, m == 3 || m == 1 || (m == 2 && p == 0)});
         end
      end
      @(posedge ref_clk);
      mode <= 2'h1;
      pm <= 1'b0;
      wst(8'h53);
      $display("register test done");
      pulse(0, 1'b0);
      st[2] = 1'b0;
      chk_st();
      pulse(1, 1'b0);
      st[3:2] = 2'b11;
      chk_st();
      pulse(5, 1'b0);
      st[3] = 1'b0;
      chk_st();
      rst_seen();
      pulse(4, 1'b1);
      st[4] = 1'b0;
      chk_st();
      rst_seen();
      for (int k = 3; k > 1; k--) begin
         pulse(k, 1'b0);
         chk_st();
         rst_seen();
      end
      $display("event test done");
      pin_low(FC - 2);
      check({7'h0, saw_rst}, 8'h00);
      pin_low(20);
      rst_seen();
      pm <= 1'b1;
      pin_low(20);
      rst_seen();
      pm <= 1'b0;
      pin_en <= 1'b0;
      tick(1);
      #1 check({7'h0, pin_pu}, 8'h00);
      pin_low(20);
      check({7'h0, saw_rst}, 8'h00);
      pin_en <= 1'b1;
      tick(1);
      #1 check({7'h0, pin_pu}, 8'h01);
      check({7'h0, pin_oe}, 8'h01);
      chk_st();
      $display("pin test done");
      src(1'b0);
      rst_seen();
      st = 8'h5c;
      chk_st();
      wst(8'h53);
      wst(8'h13);
      src(1'b1);
      check({7'h0, saw_rst}, 8'h00);
      chk_st();
      wst(8'h53);
      src(1'b1);
      rst_seen();
      st = 8'h5c | (st & 8'h02);
      chk_st();
      check(8'(q.size()), 8'h08);
      $display("supply test done");
      end_sim();
   end
endmodule
`default_nettype wire
